//--- seq_defs.vh
// Constants for the parameter-set sequencer: register offsets, field positions, reset values.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_CYCLE_CNT   12'h004
`define OFS_SELECTOR    12'h008
`define OFS_REPEAT      12'h00c
`define OFS_ACTIVE      12'h010
`define OFS_CMD         12'h014
`define OFS_STATUS      12'h018
`define OFS_BASELINE    12'h01c

// ==========================================================
// Field positions
`define CTRL_ON_BIT     0
`define CTRL_MODE_BIT   1
`define CMD_STORE_BIT   0
`define ST_BUSY_BIT     0

// ==========================================================
// Reset values, codes and limits
`define MODE_AUTO       1'b1
`define MODE_OTHER      1'b0
`define RST_CYCLE_CNT   7'h01
`define RST_REPEAT      9'h001
`define MAX_SETS        7'h40
`define MAX_REPEAT      9'h100

`endif

//--- seq_set_store.v
// Parameter-set storage: one word and one repeat count per set, with written flags.
// Assumes one write port and one combinational read port, all on pclk.
`timescale 1ns/1ns
`include "seq_defs.vh"

module seq_set_store #(
    parameter DW    = 32,
    parameter SETS  = 64,
    parameter IW    = 6
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          wr_en,
    input  wire [IW-1:0] wr_idx,
    input  wire [DW-1:0] wr_data,
    input  wire [8:0]    wr_repeat,
    input  wire [IW-1:0] rd_idx,
    input  wire [DW-1:0] dflt_data,
    output wire [DW-1:0] rd_data,
    output wire [8:0]    rd_repeat
);

    reg [DW-1:0]   data_mem [0:SETS-1];
    reg [8:0]      rep_mem  [0:SETS-1];
    reg [SETS-1:0] written_ff;

    // ==========================================================
    // Storage
    // Written flags are volatile, so every set reads as default after reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_ff <= {SETS{1'b0}};
        end else if (wr_en) begin
            written_ff[wr_idx] <= 1'b1;
        end
    end

    always @(posedge pclk) begin
        if (wr_en) begin
            data_mem[wr_idx] <= wr_data;
            rep_mem[wr_idx]  <= wr_repeat;
        end
    end

    assign rd_data   = written_ff[rd_idx] ? data_mem[rd_idx] : dflt_data;
    assign rd_repeat = written_ff[rd_idx] ? rep_mem[rd_idx] : `RST_REPEAT;

endmodule // seq_set_store

//--- seq_auto_advance.v
// Parameter-set sequencer in automatic advance mode, with APB register access.
// Assumes frame_trigger is a one-cycle pulse and frame_busy is high during exposure/readout/transfer.
// Contract
// - Auto mode steps sets in ascending order on frame triggers, by repeat count.
// - Each set is used its repeat count of frames before the next.
// - After the last set's uses, the next trigger wraps to set 0.
// - Programmable cycle set count, at most 64.
// - Enabling loads set 0 into active; first frame uses set 0.
// - Each trigger compares uses with repeat count: reuse or advance.
// - Disable during a frame finishes that frame, then stops cycling.
// - Disabling restores the active values held before enabling.
// - Selector picks the set to configure, indices 0 to 63.
// - Each set holds its own repeat count, 1 to 256.
// - Store copies the active values into the selected set.
// - Never-stored sets inside the cycle supply default values.
// - Advance-mode setting; auto behaviour only when auto is selected.
// - Stored sets are volatile and lost on reset.
// - A new current set is chosen only on frame triggers.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "seq_defs.vh"

module seq_auto_advance #(
    parameter DW = 32
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire          frame_trigger,
    input  wire          frame_busy,
    output reg  [DW-1:0] active_params,
    output reg  [5:0]    current_set,
    output reg           sequencing
);

    // ==========================================================
    // State
    reg [DW-1:0] active_ff;
    reg [DW-1:0] baseline_ff;
    reg          on_ff;
    reg          mode_ff;
    reg [6:0]    cycle_cnt_ff;
    reg [5:0]    selector_ff;
    reg [8:0]    repeat_ff;
    reg          running_ff;
    reg          stop_pend_ff;
    reg [5:0]    set_ff;
    reg [8:0]    uses_ff;
    reg          first_ff;

    wire [DW-1:0] rd_data;
    wire [8:0]    rd_repeat;
    wire          wr_phase    = psel & penable & pwrite;
    wire          setup_phase = psel & ~penable;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `OFS_CTRL) | (a == `OFS_CYCLE_CNT) | (a == `OFS_SELECTOR) |
                     (a == `OFS_REPEAT) | (a == `OFS_ACTIVE) | (a == `OFS_CMD) |
                     (a == `OFS_STATUS) | (a == `OFS_BASELINE);
        end
    endfunction

    // Full-word range checks, so stray upper bits cannot alias a legal value
    function count_ok;
        input [31:0] v;
        begin
            count_ok = (v != 32'h0000_0000) && (v <= {25'h0, `MAX_SETS});
        end
    endfunction

    function repeat_ok;
        input [31:0] v;
        begin
            repeat_ok = (v != 32'h0000_0000) && (v <= {23'h0, `MAX_REPEAT});
        end
    endfunction

    wire hit_ctrl  = wr_phase & (paddr == `OFS_CTRL);
    wire hit_active = wr_phase & (paddr == `OFS_ACTIVE);
    wire new_on    = pwdata[`CTRL_ON_BIT];
    wire enabling  = hit_ctrl & new_on & ~on_ff & ~running_ff;
    // Store commands and cycle-count and mode writes are refused while the sequencer is on or finishing
    wire locked    = on_ff | running_ff;
    wire store_cmd = wr_phase & (paddr == `OFS_CMD) & pwdata[`CMD_STORE_BIT] & ~locked;
    wire [5:0] last_set = cycle_cnt_ff[5:0] - 6'h01;
    wire [5:0] next_set = (set_ff == last_set) ? 6'h00 : set_ff + 6'h01;
    wire [8:0] set_rep  = rd_repeat;

    seq_set_store #(
        .DW   (DW),
        .SETS (64),
        .IW   (6)
    ) u_store (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (store_cmd),
        .wr_idx    (selector_ff),
        .wr_data   (active_ff),
        .wr_repeat (repeat_ff),
        .rd_idx    (running_ff ? set_ff : 6'h00),
        .dflt_data ({DW{1'b0}}),
        .rd_data   (rd_data),
        .rd_repeat (rd_repeat)
    );

    // Second read path is avoided: next set index feeds the same port by
    // holding set_ff as the index, so a one-cycle load follows each step.
    reg          load_pend_ff;

    // ==========================================================
    // Configuration registers
    reg          nxt_on;
    reg          nxt_mode;
    reg [6:0]    nxt_cycle_cnt;
    reg [5:0]    nxt_selector;
    reg [8:0]    nxt_repeat;

    always @* begin
        nxt_on        = on_ff;
        nxt_mode      = mode_ff;
        nxt_cycle_cnt = cycle_cnt_ff;
        nxt_selector  = selector_ff;
        nxt_repeat    = repeat_ff;
        if (wr_phase) begin
            case (paddr)
                `OFS_CTRL: begin
                    nxt_on = new_on;
                    // Mode moves only on a write that also leaves the sequencer off
                    if (!locked && !new_on) begin
                        nxt_mode = pwdata[`CTRL_MODE_BIT];
                    end
                end
                `OFS_CYCLE_CNT: begin
                    if (!locked && count_ok(pwdata)) begin
                        nxt_cycle_cnt = pwdata[6:0];
                    end
                end
                `OFS_SELECTOR: nxt_selector = pwdata[5:0];
                `OFS_REPEAT: begin
                    if (repeat_ok(pwdata)) begin
                        nxt_repeat = pwdata[8:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_ff        <= 1'b0;
            mode_ff      <= `MODE_AUTO;
            cycle_cnt_ff <= `RST_CYCLE_CNT;
            selector_ff  <= 6'h00;
            repeat_ff    <= `RST_REPEAT;
        end else begin
            on_ff        <= nxt_on;
            mode_ff      <= nxt_mode;
            cycle_cnt_ff <= nxt_cycle_cnt;
            selector_ff  <= nxt_selector;
            repeat_ff    <= nxt_repeat;
        end
    end

    // ==========================================================
    // Sequencer
    // Triggers landing in the load cycle are dropped, so keep them two cycles apart
    wire trig_take = frame_trigger & ~load_pend_ff;
    wire spent     = (uses_ff >= set_rep);

    reg [DW-1:0] nxt_active;
    reg [DW-1:0] nxt_baseline;
    reg          nxt_running;
    reg          nxt_stop_pend;
    reg [5:0]    nxt_set;
    reg [8:0]    nxt_uses;
    reg          nxt_first;
    reg          nxt_load_pend;

    always @* begin
        nxt_active    = active_ff;
        nxt_baseline  = baseline_ff;
        nxt_running   = running_ff;
        nxt_stop_pend = stop_pend_ff;
        nxt_set       = set_ff;
        nxt_uses      = uses_ff;
        nxt_first     = first_ff;
        nxt_load_pend = load_pend_ff;
        if (enabling && mode_ff == `MODE_AUTO) begin
            nxt_baseline  = active_ff;
            nxt_running   = 1'b1;
            nxt_stop_pend = 1'b0;
            nxt_set       = 6'h00;
            nxt_uses      = 9'h000;
            nxt_first     = 1'b1;
            nxt_load_pend = 1'b1;
        end else if (running_ff) begin
            if (load_pend_ff) begin
                nxt_active    = rd_data;
                nxt_load_pend = 1'b0;
            end
            if (!on_ff || stop_pend_ff) begin
                // Let the frame in flight finish on the current set
                if (!frame_busy) begin
                    nxt_running   = 1'b0;
                    nxt_stop_pend = 1'b0;
                    nxt_active    = baseline_ff;
                end else begin
                    nxt_stop_pend = 1'b1;
                end
            end else if (trig_take) begin
                if (first_ff) begin
                    nxt_first = 1'b0;
                    nxt_uses  = 9'h001;
                end else if (!spent) begin
                    nxt_uses = uses_ff + 9'h001;
                end else begin
                    nxt_set       = next_set;
                    nxt_uses      = 9'h001;
                    nxt_load_pend = 1'b1;
                end
            end
        end else if (hit_active) begin
            nxt_active = pwdata[DW-1:0];
        end
    end

    // ==========================================================
    // Sequencer registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff    <= {DW{1'b0}};
            baseline_ff  <= {DW{1'b0}};
            running_ff   <= 1'b0;
            stop_pend_ff <= 1'b0;
            set_ff       <= 6'h00;
            uses_ff      <= 9'h000;
            first_ff     <= 1'b0;
            load_pend_ff <= 1'b0;
        end else begin
            active_ff    <= nxt_active;
            baseline_ff  <= nxt_baseline;
            running_ff   <= nxt_running;
            stop_pend_ff <= nxt_stop_pend;
            set_ff       <= nxt_set;
            uses_ff      <= nxt_uses;
            first_ff     <= nxt_first;
            load_pend_ff <= nxt_load_pend;
        end
    end

    // ==========================================================
    // Register read mux, captured in the setup cycle
    reg [31:0] nxt_prdata;

    always @* begin
        nxt_prdata = prdata;
        if (setup_phase) begin
            case (paddr)
                `OFS_CTRL:      nxt_prdata = {30'h0, mode_ff, on_ff};
                `OFS_CYCLE_CNT: nxt_prdata = {25'h0, cycle_cnt_ff};
                `OFS_SELECTOR:  nxt_prdata = {26'h0, selector_ff};
                `OFS_REPEAT:    nxt_prdata = {23'h0, repeat_ff};
                // While sequencing, software sees the pre-enable values
                `OFS_ACTIVE:    nxt_prdata = running_ff ? baseline_ff : active_ff;
                `OFS_STATUS:    nxt_prdata = {7'h00, uses_ff, 1'b0, set_ff, 8'h00, running_ff};
                `OFS_BASELINE:  nxt_prdata = baseline_ff;
                default:        nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // APB answer and outputs; ready one cycle after setup, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h0000_0000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            active_params <= {DW{1'b0}};
            current_set   <= 6'h00;
            sequencing    <= 1'b0;
        end else begin
            prdata        <= nxt_prdata;
            pready        <= setup_phase;
            pslverr       <= setup_phase & ~mapped(paddr);
            active_params <= active_ff;
            current_set   <= set_ff;
            sequencing    <= running_ff;
        end
    end

endmodule // seq_auto_advance

//--- seq_auto_advance_asserts.sv
// Port checker for the sequencer: bus timing and set stepping.
// Assumes one pclk domain; bound onto seq_auto_advance.
`timescale 1ns/1ns
module seq_auto_advance_asserts #(
    parameter DW = 32
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [11:0]   paddr,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          frame_trigger,
    input wire logic          frame_busy,
    input wire logic [DW-1:0] active_params,
    input wire logic [5:0]    current_set,
    input wire logic          sequencing
);
    // ==========================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy_once; pready |-> $past(psel && !penable) ##1 !pready; endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("stray ready");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_unmapped; psel && !penable && paddr > 12'h01c |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    property p_start; $rose(sequencing) |-> ##[0:1] current_set == 6'h00; endproperty
    a_start: assert property (p_start) else $error("cycle not at set 0");
    property p_step; $changed(current_set) && $past(sequencing, 2) && sequencing
        |-> current_set == 6'h00 || current_set == $past(current_set) + 6'h01; endproperty
    a_step: assert property (p_step) else $error("bad set step");
    property p_trig; $changed(current_set) && $past(sequencing, 2) && sequencing
        |-> $past(frame_trigger) || $past(frame_trigger, 2); endproperty
    a_trig: assert property (p_trig) else $error("set change without trigger");
    property p_finish; sequencing && frame_busy |=> sequencing; endproperty
    a_finish: assert property (p_finish) else $error("stopped mid frame");
endmodule // seq_auto_advance_asserts

bind seq_auto_advance seq_auto_advance_asserts #(.DW(DW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .frame_trigger(frame_trigger),
    .frame_busy(frame_busy), .active_params(active_params), .current_set(current_set), .sequencing(sequencing));

//--- frame_src.sv
// Frame source: one-cycle start trigger, then busy for busy_len cycles.
// Assumes start is a one-cycle request from the bench.
`timescale 1ns/1ns
module frame_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [7:0] busy_len,
    output logic            frame_trigger,
    output logic            frame_busy
);
    // ==========================
    // Frame timing
    logic [7:0] left_ff;
    assign frame_busy = (left_ff != 8'h00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_trigger <= 1'b0;
            left_ff <= 8'h00;
        end else begin
            // No new trigger while a frame is still busy
            frame_trigger <= start & ~frame_busy;
            left_ff <= (start & ~frame_busy) ? busy_len : left_ff - {7'h00, frame_busy};
        end
    end
endmodule // frame_src

//--- seq_auto_advance_bench.sv
// Bench: register access, auto stepping, disable mid frame, reset loss.
// Assumes seq_defs.vh offsets and the frame_src partner.
`timescale 1ns/1ns
`include "seq_defs.vh"
module seq_auto_advance_bench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, active_params, rd;
    logic        pready, pslverr, frame_trigger, frame_busy, sequencing, err;
    logic [5:0]  current_set;
    logic [7:0]  busy_len = 8'h01;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;
    logic [5:0]  exp_set [6] = '{6'h00, 6'h01, 6'h01, 6'h02, 6'h00, 6'h01};
    logic [31:0] exp_dat [6] = '{32'ha0, 32'hb1, 32'hb1, 32'h0, 32'ha0, 32'hb1};

    seq_auto_advance #(.DW(32)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_trigger(frame_trigger), .frame_busy(frame_busy), .active_params(active_params),
        .current_set(current_set), .sequencing(sequencing));
    frame_src u_src (.pclk(pclk), .presetn(presetn), .start(start), .busy_len(busy_len),
        .frame_trigger(frame_trigger), .frame_busy(frame_busy));

    // ==========================
    // Tasks
    always #50 pclk = ~pclk;
    task test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after an edge; ends one idle cycle after the access
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task trig(input int i);
        start <= 1'b1;
        @(posedge pclk) start <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({26'h0, current_set}, {26'h0, exp_set[i]});
        chk(active_params, exp_dat[i]);
    endtask

    // ==========================
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`OFS_CTRL, 32'h2);
        rdc(`OFS_REPEAT, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(`OFS_CYCLE_CNT, 32'h40);
        wr(`OFS_CYCLE_CNT, 32'h41);
        rdc(`OFS_CYCLE_CNT, 32'h40);
        wr(`OFS_CYCLE_CNT, 32'h3);
        wr(`OFS_SELECTOR, 32'h0);
        wr(`OFS_ACTIVE, 32'ha0);
        wr(`OFS_CMD, 32'h1);
        wr(`OFS_SELECTOR, 32'h1);
        wr(`OFS_ACTIVE, 32'hb1);
        wr(`OFS_REPEAT, 32'h100);
        wr(`OFS_REPEAT, 32'h0);
        rdc(`OFS_REPEAT, 32'h100);
        wr(`OFS_REPEAT, 32'h2);
        wr(`OFS_CMD, 32'h1);
        wr(`OFS_ACTIVE, 32'h55);
        wr(`OFS_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        chk({31'h0, sequencing}, 32'h1);
        chk(active_params, 32'ha0);
        wr(`OFS_CYCLE_CNT, 32'h5);
        rdc(`OFS_CYCLE_CNT, 32'h3);
        // Refused store keeps set 2 at defaults, checked by the fourth trigger
        wr(`OFS_SELECTOR, 32'h2);
        wr(`OFS_CMD, 32'h1);
        rdc(`OFS_ACTIVE, 32'h55);
        // Set 2 never stored, so it plays defaults before the wrap
        for (int i = 0; i < 6; i++)
            trig(i);
        busy_len <= 8'h14;
        start <= 1'b1;
        @(posedge pclk) start <= 1'b0;
        wr(`OFS_CTRL, 32'h2);
        chk({31'h0, sequencing}, 32'h1);
        while (frame_busy === 1'b1) @(posedge pclk);
        repeat (4) @(posedge pclk);
        chk({31'h0, sequencing}, 32'h0);
        chk(active_params, 32'h55);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, sequencing}, 32'h0);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CTRL, 32'h2);
        wr(`OFS_ACTIVE, 32'h77);
        wr(`OFS_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        chk(active_params, 32'h0);
        test_done;
    end
endmodule // seq_auto_advance_bench
